/* hdl/cmp_regs.svh */
// Register offsets, field positions, reset values for the comparator control block
`ifndef CMP_REGS_SVH
`define CMP_REGS_SVH
// Register indices; byte address is four times the index
`define CMP_IDX_PORT     8'h05
`define CMP_IDX_IRQCTL   8'h0b
`define CMP_IDX_FLAG     8'h0c
`define CMP_IDX_MODE     8'h19
`define CMP_IDX_GATE     8'h1a
`define CMP_IDX_DIR      8'h85
`define CMP_IDX_EN       8'h8c
`define CMP_IDX_REF      8'h99
// Field positions
`define CMP_RES_LSB      6
`define CMP_INV_LSB      4
`define CMP_CIS_BIT      3
`define CMP_FLAG_LSB     3
`define CMP_GIE_BIT      7
`define CMP_PERIPHERAL_IRQ_EN_BIT     6
`define CMP_GSS_BIT      1
`define CMP_SYNC_BIT     0
`define CMP_DIR_LSB      2
// Reset values
`define CMP_MODE_RST     8'h00
`define CMP_GATE_RST     2'h2
`define CMP_REF_RST      8'h00
`define CMP_DIR_RST      2'h3
// Mode codes
`define CMP_CM_RESET     3'h0
`define CMP_CM_OFF       3'h7
`define CMP_CM_ROUTE     3'h6
// Bus answers
`define CMP_RESP_OKAY    2'h0
`define CMP_RESP_SLVERR  2'h2
`endif

/* hdl/cmp_pkg.sv */
// Types shared by the comparator control block
package cmp_pkg;
   // One driven pin: level and enable
   typedef struct packed {
      logic out;
      logic oe;
   } cmp_pin_s;
   // Reference ladder settings
   typedef struct packed {
      logic       power_on;
      logic       range_sel;
      logic [3:0] level_code;
   } cmp_ref_s;
endpackage : cmp_pkg

/* hdl/cmp_ctrl.sv */
// Dual comparator control with AXI4-Lite register slave
// Function
// [R1] Raw result high when plus exceeds minus
// [R2] Per-comparator invert bit complements result
// [R3] Three-bit mode field; 111 turns off
// [R4] Results read-only in mode register
// [R5] Routing drives pins with adjusted result
// [R6] Direction bits still gate pin drive
// [R7] Gate source select, resets to one
// [R8] Sync bit latches comparator 2 on fall
// [R9] Prescaled clock feeds latch when used
// [R10] Counter ticks on rising clock edge
// [R11] Software sets sync when gating by comparator
// [R12] Change flags set on result change
// [R13] Write zero clears, write one sets
// [R14] Request needs flag, enables, global enable
// [R15] Mismatch persists until mode register access
// [R16] Change during mode read may be lost
// [R17] Software masks interrupts during mode change
// [R18] Sleep wake; vector only with global enable
// [R19] Wake leaves configuration registers unchanged
// [R20] Reset restores defaults, mode 000
// [R21] Analog pins read zero from port
// [R22] Reference: four-bit level, range bit
// [R23] Stored copy refreshed on mode access
`timescale 1ns/1ps
`include "cmp_regs.svh"
module cmp_ctrl #(
   parameter int ADDR_W = 12
) (
   input  wire logic              mclk,
   input  wire logic              reset_n,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic [1:0]        comparator_result_raw,
   input  wire logic [5:0]        pin_level,
   input  wire logic [5:0]        pin_analog,
   input  wire logic              timer_gate_pin,
   input  wire logic              timer_clk_raw,
   input  wire logic              timer_clk_prescaled,
   input  wire logic              prescaler_used,
   output cmp_pkg::cmp_pin_s      first_result_pin,
   output cmp_pkg::cmp_pin_s      second_result_pin,
   output logic                   timer_gate,
   output logic                   counter_tick,
   output cmp_pkg::cmp_ref_s      reference_cfg,
   output logic                   irq_req,
   output logic                   wake_req,
   output logic                   vector_take
);

   // Register indices need the address to reach index 0x99
   if (ADDR_W < 10) begin : g_addr_chk
      $error("ADDR_W too small for the register map");
   end

   // Register state
   logic [1:0] result_invert;         // Per-comparator polarity
   logic       input_switch_sel;      // Input switch bit
   logic [2:0] comparator_config_field;
   logic       timer_gate_source_sel; // 1 gate pin, 0 comparator 2
   logic       second_result_sync;    // Latch comparator 2 on fall
   logic [7:0] ref_reg;               // Reference control image
   logic [1:0] result_change_flag;
   logic [1:0] result_change_irq_en;
   logic       peripheral_irq_en;
   logic       global_irq_en;
   logic [1:0] pin_direction_bits;    // 1 means input

   // Datapath state
   logic [1:0] comparator_result;     // Polarity-adjusted result
   logic [1:0] stored_result;         // Copy taken on mode access
   logic [1:0] mismatch;
   logic       second_latched;        // Comparator 2 after sync latch
   logic       tclk_src;              // Selected counter clock
   logic       tclk_prev;             // Clock level one cycle ago
   logic       tclk_fall;
   logic       cmp_off;

   // Bus decode
   logic       wr_go;                 // Write address and data taken
   logic       rd_go;                 // Read address taken
   logic [7:0] widx;
   logic [7:0] ridx;
   logic       mode_access;
   logic [7:0] wbyte;
   logic       wr_hit;
   logic [7:0] next_rdata;
   logic       rd_hit;

   assign widx  = awaddr[9:2];
   assign ridx  = araddr[9:2];
   assign wbyte = wdata[7:0];

   // Both write channels taken together, one write in flight
   assign awready = awvalid & wvalid & ~bvalid;
   assign wready  = awready;
   assign wr_go   = awready;
   // One read in flight
   assign arready = ~rvalid;
   assign rd_go   = arvalid & ~rvalid;

   // Any read or write of the mode register
   assign mode_access = (wr_go && widx == `CMP_IDX_MODE) ||
                        (rd_go && ridx == `CMP_IDX_MODE); // [R15]

   // Write address hit check
   always_comb begin
      unique case (widx)
         `CMP_IDX_PORT, `CMP_IDX_IRQCTL, `CMP_IDX_FLAG, `CMP_IDX_MODE,
         `CMP_IDX_GATE, `CMP_IDX_DIR, `CMP_IDX_EN, `CMP_IDX_REF: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Write response
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         bvalid <= 1'b0;
         bresp  <= `CMP_RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp  <= wr_hit ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Mode register; result bits are not stored so writes miss them
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         {result_invert, input_switch_sel, comparator_config_field}
            <= 6'(`CMP_MODE_RST); // [R20]
      end else if (wr_go && wstrb[0] && widx == `CMP_IDX_MODE) begin
         result_invert           <= wbyte[`CMP_INV_LSB +: 2]; // [R4]
         input_switch_sel        <= wbyte[`CMP_CIS_BIT];
         comparator_config_field <= wbyte[2:0]; // [R3]
      end
   end

   // Gate and sync configuration
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         {timer_gate_source_sel, second_result_sync} <= `CMP_GATE_RST; // [R7] [R8]
      end else if (wr_go && wstrb[0] && widx == `CMP_IDX_GATE) begin
         timer_gate_source_sel <= wbyte[`CMP_GSS_BIT];
         second_result_sync    <= wbyte[`CMP_SYNC_BIT];
      end
   end

   // Reference control; unimplemented bits kept at zero
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ref_reg <= `CMP_REF_RST; // [R20]
      end else if (wr_go && wstrb[0] && widx == `CMP_IDX_REF) begin
         ref_reg <= wbyte & 8'haf; // [R22]
      end
   end

   // Enables and pin directions; no wake path touches these
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         result_change_irq_en <= 2'h0;
         peripheral_irq_en    <= 1'b0;
         global_irq_en        <= 1'b0;
         pin_direction_bits   <= `CMP_DIR_RST;
      end else if (wr_go && wstrb[0]) begin
         if (widx == `CMP_IDX_EN) begin
            result_change_irq_en <= wbyte[`CMP_FLAG_LSB +: 2];
         end
         if (widx == `CMP_IDX_IRQCTL) begin
            peripheral_irq_en <= wbyte[`CMP_PERIPHERAL_IRQ_EN_BIT];
            global_irq_en     <= wbyte[`CMP_GIE_BIT];
         end
         if (widx == `CMP_IDX_DIR) begin
            pin_direction_bits <= wbyte[`CMP_DIR_LSB +: 2];
         end
      end
   end

   // Comparators off in reset mode and off mode
   assign cmp_off = (comparator_config_field == `CMP_CM_OFF) ||
                    (comparator_config_field == `CMP_CM_RESET); // [R3]
   // Raw high means plus above minus, then polarity
   assign comparator_result = (cmp_off ? 2'h0 : comparator_result_raw)
                              ^ result_invert; // [R1] [R2]
   assign mismatch = comparator_result ^ stored_result; // [R23]

   // Per-comparator change detector and flag
   for (genvar i = 0; i < 2; i++) begin : g_chg
      // Stored copy refreshed on each mode register access
      always_ff @(posedge mclk) begin
         if (!reset_n) begin
            stored_result[i] <= 1'b0;
         end else if (mode_access) begin
            stored_result[i] <= comparator_result[i]; // [R23] [R16]
         end
      end
      // Hardware set wins over a software clear
      always_ff @(posedge mclk) begin
         if (!reset_n) begin
            result_change_flag[i] <= 1'b0;
         end else if (mismatch[i]) begin
            result_change_flag[i] <= 1'b1; // [R12] [R15]
         end else if (wr_go && wstrb[0] && widx == `CMP_IDX_FLAG) begin
            result_change_flag[i] <= wbyte[`CMP_FLAG_LSB + i]; // [R13]
         end
      end
   end

   // Counter clock source and edges
   assign tclk_src  = prescaler_used ? timer_clk_prescaled : timer_clk_raw; // [R9]
   assign tclk_fall = tclk_prev & ~tclk_src;
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         tclk_prev <= 1'b0;
      end else begin
         tclk_prev <= tclk_src;
      end
   end
   // Counter steps on the rising edge, opposite to the latch
   assign counter_tick = ~tclk_prev & tclk_src; // [R10]

   // Comparator 2 sync latch, loaded on the falling edge
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         second_latched <= 1'b0;
      end else if (tclk_fall) begin
         second_latched <= comparator_result[1]; // [R8]
      end
   end

   // Gate source; software keeps sync set when using comparator 2
   assign timer_gate = timer_gate_source_sel ? timer_gate_pin :
                       (second_result_sync ? second_latched
                                           : comparator_result[1]); // [R7] [R11]

   // Pin routing; direction bit still enables the driver
   assign first_result_pin.out  = comparator_result[0]; // [R5]
   assign second_result_pin.out = comparator_result[1]; // [R5]
   assign first_result_pin.oe   = (comparator_config_field == `CMP_CM_ROUTE)
                                  & ~pin_direction_bits[0]; // [R6]
   assign second_result_pin.oe  = (comparator_config_field == `CMP_CM_ROUTE)
                                  & ~pin_direction_bits[1]; // [R6]

   // Reference settings out
   assign reference_cfg = {ref_reg[7], ref_reg[5], ref_reg[3:0]}; // [R22]

   // Interrupt path; software masks it around mode changes
   assign wake_req    = |(result_change_flag & result_change_irq_en)
                        & peripheral_irq_en; // [R18] [R17]
   assign irq_req     = wake_req & global_irq_en; // [R14]
   assign vector_take = irq_req; // [R18] [R19]

   // Read data mux
   always_comb begin
      next_rdata = 8'h00;
      rd_hit     = 1'b1;
      unique case (ridx)
         `CMP_IDX_PORT:   next_rdata = {2'h0, pin_level & ~pin_analog}; // [R21]
         `CMP_IDX_IRQCTL: next_rdata = {global_irq_en, peripheral_irq_en, 6'h00};
         `CMP_IDX_FLAG:   next_rdata = {3'h0, result_change_flag, 3'h0};
         `CMP_IDX_MODE:   next_rdata = {comparator_result, result_invert,
                                        input_switch_sel,
                                        comparator_config_field}; // [R4]
         `CMP_IDX_GATE:   next_rdata = {6'h00, timer_gate_source_sel,
                                        second_result_sync};
         `CMP_IDX_DIR:    next_rdata = {4'h0, pin_direction_bits, 2'h0};
         `CMP_IDX_EN:     next_rdata = {3'h0, result_change_irq_en, 3'h0};
         `CMP_IDX_REF:    next_rdata = ref_reg;
         default:         rd_hit = 1'b0;
      endcase
   end

   // Read response
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= `CMP_RESP_OKAY;
      end else if (rd_go) begin
         rvalid <= 1'b1;
         rdata  <= {24'h0, next_rdata};
         rresp  <= rd_hit ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   flag_on_change_a: assert property (mismatch[0] |=> result_change_flag[0]) // [R12]
      else $error("flag 0 not set after change");
   flag_sw_clear_a: assert property (wr_go && wstrb[0] && widx == `CMP_IDX_FLAG
      && !wbyte[3] && !mismatch[0] |=> !result_change_flag[0]) // [R13]
      else $error("flag 0 not cleared by write");
   access_ends_mismatch_a: assert property (mode_access && $stable(comparator_result)
      ##1 $stable(comparator_result) |-> mismatch == 2'h0) // [R15]
      else $error("mismatch kept after access");
   invert_path_a: assert property (!cmp_off |-> first_result_pin.out ==
      (comparator_result_raw[0] ^ result_invert[0])) // [R2]
      else $error("polarity wrong");
   off_mode_a: assert property (comparator_config_field == `CMP_CM_OFF
      |-> comparator_result == result_invert) // [R3]
      else $error("off mode result wrong");
   gate_select_a: assert property (!timer_gate_source_sel && !second_result_sync
      |-> timer_gate == comparator_result[1]) // [R7]
      else $error("gate source wrong");
   sync_latch_a: assert property (tclk_fall |=> second_latched == $past(comparator_result[1])) // [R8]
      else $error("latch missed falling edge");
   tick_rise_a: assert property (counter_tick |-> !$past(tclk_src) && tclk_src) // [R10]
      else $error("tick not on rising edge");
   irq_gate_a: assert property (irq_req |-> global_irq_en && peripheral_irq_en
      && |(result_change_flag & result_change_irq_en)) // [R14]
      else $error("request without enables");
   pin_oe_a: assert property (pin_direction_bits[1] |-> !second_result_pin.oe) // [R6]
      else $error("pin driven while input");
   write_resp_a: assert property (wr_go |=> bvalid ##0 bresp ==
      ($past(wr_hit) ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR))
      else $error("write answer wrong");

   flag_set_c: cover property (mismatch[1] ##1 result_change_flag[1]);
   irq_fire_c: cover property (!irq_req ##1 irq_req);
   sync_gate_c: cover property (second_result_sync && tclk_fall);
   unmapped_rd_c: cover property (rd_go && !rd_hit);

endmodule : cmp_ctrl

/* testbench/cmp_partner_model.sv */
// Model of the analog comparators and of the counter clock and gate sources
`timescale 1ns/1ps
module cmp_partner_model (
   input  wire logic       mclk,
   input  wire logic [7:0] vin_plus,
   input  wire logic [7:0] vin_minus,
   input  wire logic [1:0] clk_run,
   input  wire logic       gate_level,
   output logic [1:0]      raw_out,
   output logic            tclk_raw,
   output logic            tclk_pre,
   output logic            gate_pin
);
   logic [3:0] div   = 4'h0; // Free divider of the system clock
   logic [1:0] run_q = 2'h0; // Run enables taken at a clean phase
   // Divider runs always
   always @(posedge mclk) begin
      div <= div + 4'h1;
   end
   // Enables change only at phase zero, so clocks start and stop low without slivers
   always @(posedge mclk) begin
      if (div == 4'h0) begin
         run_q <= clk_run;
      end
   end
   // Raw clock period 4 cycles, prescaled 16; both stand still low when stopped
   assign tclk_raw   = run_q[0] & div[1];
   assign tclk_pre   = run_q[1] & div[3];
   // Output high only when the plus level exceeds the minus level
   assign raw_out[0] = vin_plus[3:0] > vin_minus[3:0];
   assign raw_out[1] = vin_plus[7:4] > vin_minus[7:4];
   assign gate_pin   = gate_level;
endmodule : cmp_partner_model

/* testbench/cmp_ctrl_tb.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "cmp_regs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module cmp_ctrl_tb;
   logic              mclk, reset_n;                           // Clock and reset
   logic [11:0]       awaddr, araddr;                          // Bus addresses
   logic              awvalid, wvalid, bready, arvalid, rready; // Master side
   logic              awready, wready, bvalid, arready, rvalid; // Slave side
   logic [31:0]       wdata, rdata, rd_v;                      // Data and last read
   logic [1:0]        bresp, rresp, wr_resp, rd_resp, raw, run;
   logic [5:0]        pin_level, pin_analog;                   // Port pins
   logic              gp, gl, tcr, tcp, pre_used, timer_gate, counter_tick;
   logic              irq_req, wake_req, vector_take, counting;
   logic [7:0]        vp, vm;                                  // Analog levels
   cmp_pkg::cmp_pin_s p1, p2;                                  // Routed pins
   cmp_pkg::cmp_ref_s refc;                                    // Reference settings
   int                n_fail = 0, check_count = 0, ticks = 0;
   cmp_ctrl #(.ADDR_W(12)) dut (.mclk, .reset_n, .awaddr, .awvalid, .awready, .wdata,
      .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .comparator_result_raw(raw), .pin_level, .pin_analog,
      .timer_gate_pin(gp), .timer_clk_raw(tcr), .timer_clk_prescaled(tcp),
      .prescaler_used(pre_used), .first_result_pin(p1), .second_result_pin(p2), .timer_gate,
      .counter_tick, .reference_cfg(refc), .irq_req, .wake_req, .vector_take);
   cmp_partner_model far (.mclk, .vin_plus(vp), .vin_minus(vm), .clk_run(run),
      .gate_level(gl), .raw_out(raw), .tclk_raw(tcr), .tclk_pre(tcp), .gate_pin(gp));
   // System clock, 10 ns
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Counts counter ticks inside a window
   always @(posedge mclk) begin
      if (counting && counter_tick === 1'b1) begin
         ticks++;
      end
   end
   // Byte address of a register index
   function automatic logic [11:0] ad(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction : ad
   // Write: address and data offered together, held until taken
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      @(posedge mclk);
      awaddr  <= ad(i);
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do @(posedge mclk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      while (!bvalid) @(posedge mclk);
      wr_resp = bresp;
      bready  <= 1'b0;
   endtask : wr
   // Read: address held until taken, data taken at the answer edge
   task automatic rd(input logic [7:0] i);
      @(posedge mclk);
      araddr  <= ad(i);
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge mclk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge mclk);
      rd_v    = rdata;
      rd_resp = rresp;
      rready  <= 1'b0;
   endtask : rd
   // Read and compare the whole word
   task automatic rc(input logic [7:0] i, input logic [7:0] e, input string nm);
      rd(i);
      `CHK(nm, {24'h0, e}, rd_v)
   endtask : rc
   // Drive comparator inputs so that each result goes high or low, then let it settle
   task automatic set_in(input logic [1:0] hi);
      @(posedge mclk);
      vp <= {hi[1] ? 4'h9 : 4'h3, hi[0] ? 4'h9 : 4'h3};
      repeat (3) @(posedge mclk);
   endtask : set_in
   task automatic do_reset();
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
   endtask : do_reset
   task automatic t_reset();
      rc(`CMP_IDX_MODE, 8'h00, "mode");
      rc(`CMP_IDX_GATE, 8'h02, "gate");
      rc(`CMP_IDX_REF, 8'h00, "ref");
      rc(`CMP_IDX_DIR, 8'h0c, "dir");
   endtask : t_reset
   // Results, inversion, read-only bits and off mode
   task automatic t_results();
      wr(`CMP_IDX_MODE, 8'h02);
      set_in(2'b01);
      rc(`CMP_IDX_MODE, 8'h42, "res");
      wr(`CMP_IDX_MODE, 8'hc2);
      set_in(2'b00);
      rc(`CMP_IDX_MODE, 8'h02, "ro");
      wr(`CMP_IDX_MODE, 8'h32);
      set_in(2'b01);
      rc(`CMP_IDX_MODE, 8'hb2, "inv");
      wr(`CMP_IDX_MODE, 8'h37);
      set_in(2'b11);
      rc(`CMP_IDX_MODE, 8'hf7, "off inv");
      wr(`CMP_IDX_MODE, 8'h07);
      rc(`CMP_IDX_MODE, 8'h07, "off");
   endtask : t_results
   // Routing to pins, direction bits as output enables
   task automatic t_route();
      wr(`CMP_IDX_MODE, 8'h16);
      set_in(2'b01);
      wr(`CMP_IDX_DIR, 8'h08);
      `CHK("pin1", 2'b01, p1)
      `CHK("pin2", 2'b00, p2)
      set_in(2'b00);
      `CHK("pin1 b", 2'b11, p1)
   endtask : t_route
   // Change flags, mismatch, software set and request gating
   task automatic t_flags();
      wr(`CMP_IDX_MODE, 8'h02);
      rd(`CMP_IDX_MODE);
      wr(`CMP_IDX_FLAG, 8'h00);
      rc(`CMP_IDX_FLAG, 8'h00, "clr");
      set_in(2'b01);
      rc(`CMP_IDX_FLAG, 8'h08, "chg");
      wr(`CMP_IDX_FLAG, 8'h00);
      rc(`CMP_IDX_FLAG, 8'h08, "mism");
      rd(`CMP_IDX_MODE);
      wr(`CMP_IDX_FLAG, 8'h00);
      rc(`CMP_IDX_FLAG, 8'h00, "end");
      wr(`CMP_IDX_FLAG, 8'h10);
      rc(`CMP_IDX_FLAG, 8'h10, "sw set");
      wr(`CMP_IDX_EN, 8'h10);
      wr(`CMP_IDX_IRQCTL, 8'h40);
      `CHK("irq", 1'b0, irq_req)
      `CHK("wake", 1'b1, wake_req)
      wr(`CMP_IDX_IRQCTL, 8'hc0);
      `CHK("irq g", 1'b1, irq_req)
      `CHK("vec", 1'b1, vector_take)
      wr(`CMP_IDX_EN, 8'h00);
      `CHK("irq m", 1'b0, irq_req)
   endtask : t_flags
   // Gate source, sync latch, prescaled latch clock and tick edge
   task automatic t_gate();
      gl <= 1'b1;
      set_in(2'b00);
      `CHK("gate pin", 1'b1, timer_gate)
      wr(`CMP_IDX_GATE, 8'h00);
      set_in(2'b10);
      `CHK("gate c2", 1'b1, timer_gate)
      wr(`CMP_IDX_GATE, 8'h01);
      // No counter clock yet: latch keeps its reset level while comparator 2 is high
      `CHK("hold", 1'b0, timer_gate)
      run <= 2'b01;
      repeat (24) @(posedge mclk);
      `CHK("latched", 1'b1, timer_gate)
      set_in(2'b00);
      repeat (24) @(posedge mclk);
      `CHK("latched 0", 1'b0, timer_gate)
      pre_used <= 1'b1;
      set_in(2'b10);
      repeat (24) @(posedge mclk);
      `CHK("pre hold", 1'b0, timer_gate)
      run <= 2'b10;
      repeat (48) @(posedge mclk);
      `CHK("pre latch", 1'b1, timer_gate)
      run <= 2'b00;
      repeat (40) @(posedge mclk);
      ticks = 0;
      counting <= 1'b1;
      run <= 2'b10;
      while (!tcp) @(posedge mclk);
      repeat (4) @(posedge mclk);
      `CHK("tick rise", 1, ticks)
      repeat (8) @(posedge mclk);
      `CHK("tick fall", 1, ticks)
      run <= 2'b00;
      counting <= 1'b0;
   endtask : t_gate
   // Reference, port, unmapped access and reset in mid-run
   task automatic t_misc();
      wr(`CMP_IDX_REF, 8'h2a);
      `CHK("refc", 6'h1a, refc)
      rc(`CMP_IDX_REF, 8'h2a, "ref");
      pin_level  <= 6'h3f;
      pin_analog <= 6'h05;
      rc(`CMP_IDX_PORT, 8'h3a, "port");
      rd(8'hff);
      `CHK("rresp", `CMP_RESP_SLVERR, rd_resp)
      wr(8'hff, 8'h55);
      `CHK("bresp", `CMP_RESP_SLVERR, wr_resp)
      do_reset();
      rc(`CMP_IDX_REF, 8'h00, "ref rst");
      rc(`CMP_IDX_GATE, 8'h02, "gate rst");
      rc(`CMP_IDX_MODE, 8'h00, "mode rst");
   endtask : t_misc
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // Main sequence
   initial begin
      reset_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, run, gl, pre_used, counting} = '0;
      {awaddr, araddr, wdata, pin_level, pin_analog} = '0;
      vp = 8'h33;
      vm = 8'h66;
      do_reset();
      t_reset();
      t_results();
      t_route();
      t_flags();
      t_gate();
      t_misc();
      give_verdict();
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      give_verdict();
   end
endmodule : cmp_ctrl_tb
